// [hw/crc16_byte_step.sv]
// one byte of crc division, purely combinational
// assumes the caller registers the result
`timescale 1ns/1ps
module crc16_byte_step (
  // running remainder and dividend byte, already msb-first
  input  wire logic [crc16_pkg::CRC_W-1:0]  rem_i,
  input  wire logic [crc16_pkg::BYTE_W-1:0] dvd_i,
  // next remainder
  output logic      [crc16_pkg::CRC_W-1:0]  next_o
);

  assign next_o = crc16_pkg::crc_step(rem_i, dvd_i);

endmodule : crc16_byte_step

// [hw/crc16_ccitt_byte_engine.sv]
// software-driven 16-bit ccitt crc engine fed one byte per register write
// assumes a master on clk_i that never issues read and write together
//
// What this block does
// - divide modulo 2 by x^16 + x^12 + x^5 + 1
// - code is 16 bits wide, data arrives in 8-bit units
// - each byte written to the input register triggers one update step
// - the new code stands in the result register two cycles after the write
// - each written byte is bit-reversed, bit 0 becoming the dividend msb
// - reversed byte times x^16 plus remainder, reduced by the polynomial
// - reading the result register returns the remainder bit-reversed
// - the remainder stays as running state for the next byte
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module crc16_ccitt_byte_engine (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // register port
  input  wire logic [crc16_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [crc16_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                         we_i,
  input  wire logic                         re_i,
  output logic      [crc16_pkg::DATA_W-1:0] rdata_o
);

  logic [crc16_pkg::CRC_W-1:0]  rem_q;
  logic [crc16_pkg::CRC_W-1:0]  rem_d;
  logic [crc16_pkg::BYTE_W-1:0] byte_q;
  crc16_pkg::byte_stage_t       stage_q;
  logic [crc16_pkg::DATA_W-1:0] rdata_q;
  logic [crc16_pkg::DATA_W-1:0] rdata_d;
  logic [crc16_pkg::CRC_W-1:0]  step_next;
  logic [crc16_pkg::BYTE_W-1:0] step_byte;

  // address decode
  wire sel_res  = (addr_i == crc16_pkg::RESULT_OFF);
  wire sel_byte = (addr_i == crc16_pkg::BYTE_IN_OFF);
  wire wr_res   = we_i && sel_res;
  wire wr_byte  = we_i && sel_byte;
  wire rd_res   = re_i && sel_res;
  wire rd_byte  = re_i && sel_byte;

  // bit 0 of the written byte leads the division
  assign step_byte = crc16_pkg::rev8(stage_q.data);

  crc16_byte_step u_step (
    .rem_i  (rem_q),
    .dvd_i  (step_byte),
    .next_o (step_next)
  );

  // a software load wins over a pending step so a fresh block starts clean
  assign rem_d = wr_res       ? wdata_i[crc16_pkg::CRC_W-1:0] :
                 stage_q.pend ? step_next :
                                rem_q;

  // read mux, bits above the byte read as zero
  assign rdata_d = rd_res  ? crc16_pkg::rev16(rem_q) :
                   rd_byte ? {{(crc16_pkg::DATA_W-crc16_pkg::BYTE_W){1'b0}}, byte_q} :
                   re_i    ? crc16_pkg::UNMAPPED_RD :
                             rdata_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rem_q <= crc16_pkg::RESULT_RST;
    end else begin
      rem_q <= rem_d;
    end
  end

  // byte capture in the write cycle, division in the next: two-cycle latency
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stage_q <= crc16_pkg::STAGE_RST;
      byte_q  <= crc16_pkg::BYTE_RST;
    end else begin
      stage_q.pend <= wr_byte;
      if (wr_byte) begin
        stage_q.data <= wdata_i[crc16_pkg::BYTE_W-1:0];
        byte_q       <= wdata_i[crc16_pkg::BYTE_W-1:0];
      end
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= crc16_pkg::RDATA_RST;
    end else if (re_i) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= crc16_pkg::RDATA_RST;
    end
  end

  assign rdata_o = rdata_q;

  property p_poly_known;
    @(posedge clk_i) disable iff (rst_i)
      (stage_q.pend && !wr_res && rem_q == 16'h0000 && step_byte == 8'h80)
      |=> (rem_q == 16'h9188);
  endproperty
  a_poly_known: assert property (p_poly_known)
    else $error("step of 80 on zero remainder is not 9188");

  property p_byte_read_zero_high;
    @(posedge clk_i) disable iff (rst_i)
      rd_byte |=> (rdata_o == {8'h00, $past(byte_q)});
  endproperty
  a_byte_read_zero_high: assert property (p_byte_read_zero_high)
    else $error("byte input read back wrong or high bits set");

  property p_write_triggers;
    @(posedge clk_i) disable iff (rst_i)
      wr_byte |=> (stage_q.pend && stage_q.data == $past(wdata_i[7:0]));
  endproperty
  a_write_triggers: assert property (p_write_triggers)
    else $error("byte write did not start an update");

  property p_two_cycles;
    @(posedge clk_i) disable iff (rst_i)
      (wr_byte && !stage_q.pend) ##1 (!wr_byte && !wr_res)
      |=> (!stage_q.pend && rem_q == crc16_pkg::crc_step($past(rem_q),
                                                         crc16_pkg::rev8($past(byte_q))));
  endproperty
  a_two_cycles: assert property (p_two_cycles)
    else $error("code not ready two cycles after byte write");

  property p_reverse;
    @(posedge clk_i) disable iff (rst_i)
      stage_q.pend |-> (step_byte[7] == stage_q.data[0] && step_byte[0] == stage_q.data[7]);
  endproperty
  a_reverse: assert property (p_reverse)
    else $error("written byte not reversed before division");

  property p_step_update;
    @(posedge clk_i) disable iff (rst_i)
      (stage_q.pend && !wr_res)
      |=> (rem_q == crc16_pkg::crc_step($past(rem_q), $past(step_byte)));
  endproperty
  a_step_update: assert property (p_step_update)
    else $error("remainder did not take the division result");

  property p_result_read;
    @(posedge clk_i) disable iff (rst_i)
      rd_res |=> (rdata_o == crc16_pkg::rev16($past(rem_q)));
  endproperty
  a_result_read: assert property (p_result_read)
    else $error("result read is not the reversed remainder");

  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
      (!stage_q.pend && !wr_res) |=> $stable(rem_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("remainder changed without a byte or load");

  property p_load_value;
    @(posedge clk_i) disable iff (rst_i)
      wr_res |=> (rem_q == $past(wdata_i[crc16_pkg::CRC_W-1:0]));
  endproperty
  a_load_value: assert property (p_load_value)
    else $error("result write did not load the remainder as written");

  property p_load_wins;
    @(posedge clk_i) disable iff (rst_i)
      (wr_res && stage_q.pend) |=> (rem_q == $past(wdata_i[crc16_pkg::CRC_W-1:0]));
  endproperty
  a_load_wins: assert property (p_load_wins)
    else $error("pending step overrode a result write");

  property p_load_then_read;
    @(posedge clk_i) disable iff (rst_i)
      wr_res ##1 rd_res
      |=> (rdata_o == crc16_pkg::rev16($past(wdata_i[crc16_pkg::CRC_W-1:0], 2)));
  endproperty
  a_load_then_read: assert property (p_load_then_read)
    else $error("loaded start value not read back reversed");

  property p_pend_one_shot;
    @(posedge clk_i) disable iff (rst_i)
      (stage_q.pend && !wr_byte) |=> !stage_q.pend;
  endproperty
  a_pend_one_shot: assert property (p_pend_one_shot)
    else $error("update step ran more than once for one byte");

  property p_no_spurious_pend;
    @(posedge clk_i) disable iff (rst_i)
      !wr_byte |=> !stage_q.pend;
  endproperty
  a_no_spurious_pend: assert property (p_no_spurious_pend)
    else $error("update step started without a byte write");

  property p_unmapped_write;
    @(posedge clk_i) disable iff (rst_i)
      (we_i && !sel_res && !sel_byte) |=> (!stage_q.pend && $stable(byte_q));
  endproperty
  a_unmapped_write: assert property (p_unmapped_write)
    else $error("unmapped write disturbed the engine");

  property p_stage_data_hold;
    @(posedge clk_i) disable iff (rst_i)
      !wr_byte |=> $stable(stage_q.data);
  endproperty
  a_stage_data_hold: assert property (p_stage_data_hold)
    else $error("staged byte changed without a write");

  property p_byte_capture;
    @(posedge clk_i) disable iff (rst_i)
      wr_byte |=> (byte_q == $past(wdata_i[crc16_pkg::BYTE_W-1:0]));
  endproperty
  a_byte_capture: assert property (p_byte_capture)
    else $error("input register did not keep the low byte");

  property p_byte_hold;
    @(posedge clk_i) disable iff (rst_i)
      !wr_byte |=> $stable(byte_q);
  endproperty
  a_byte_hold: assert property (p_byte_hold)
    else $error("input register changed without a write");

  property p_old_until_step;
    @(posedge clk_i) disable iff (rst_i)
      (wr_byte && !stage_q.pend) |=> $stable(rem_q);
  endproperty
  a_old_until_step: assert property (p_old_until_step)
    else $error("remainder moved in the byte write cycle itself");

  property p_ready_visible;
    @(posedge clk_i) disable iff (rst_i)
      wr_byte ##1 !wr_res ##1 rd_res
      |=> (rdata_o == crc16_pkg::rev16(crc16_pkg::crc_step($past(rem_q, 2),
                                                           $past(step_byte, 2))));
  endproperty
  a_ready_visible: assert property (p_ready_visible)
    else $error("read two cycles after a byte write missed the new code");

  property p_reverse_mid;
    @(posedge clk_i) disable iff (rst_i)
      stage_q.pend |-> (step_byte[6] == stage_q.data[1] && step_byte[1] == stage_q.data[6]);
  endproperty
  a_reverse_mid: assert property (p_reverse_mid)
    else $error("bits 1 and 6 of the byte not swapped");

  property p_reverse_core;
    @(posedge clk_i) disable iff (rst_i)
      stage_q.pend |-> (step_byte[5] == stage_q.data[2] && step_byte[2] == stage_q.data[5] &&
                        step_byte[4] == stage_q.data[3] && step_byte[3] == stage_q.data[4]);
  endproperty
  a_reverse_core: assert property (p_reverse_core)
    else $error("inner bits of the byte not swapped");

  property p_poly_one;
    @(posedge clk_i) disable iff (rst_i)
      (stage_q.pend && !wr_res && rem_q == 16'h0000 && step_byte == 8'h01)
      |=> (rem_q == 16'h1021);
  endproperty
  a_poly_one: assert property (p_poly_one)
    else $error("single dividend bit did not leave the polynomial");

  property p_poly_second;
    @(posedge clk_i) disable iff (rst_i)
      (stage_q.pend && !wr_res && rem_q == 16'h9188 && step_byte == 8'hC4)
      |=> (rem_q == 16'h8250);
  endproperty
  a_poly_second: assert property (p_poly_second)
    else $error("second step of the known sequence is wrong");

  property p_zero_step;
    @(posedge clk_i) disable iff (rst_i)
      (stage_q.pend && !wr_res && rem_q == 16'h0000 && step_byte == 8'h00)
      |=> (rem_q == 16'h0000);
  endproperty
  a_zero_step: assert property (p_zero_step)
    else $error("zero byte on zero remainder gave a nonzero code");

  property p_accumulate;
    @(posedge clk_i) disable iff (rst_i)
      (stage_q.pend && !wr_res) ##1 (stage_q.pend && !wr_res)
      |=> (rem_q == crc16_pkg::crc_step(crc16_pkg::crc_step($past(rem_q, 2),
                                                            $past(step_byte, 2)),
                                        $past(step_byte)));
  endproperty
  a_accumulate: assert property (p_accumulate)
    else $error("back to back bytes did not accumulate");

  property p_changed_cause;
    @(posedge clk_i) disable iff (rst_i)
      $changed(rem_q) |-> ($past(stage_q.pend) || $past(wr_res));
  endproperty
  a_changed_cause: assert property (p_changed_cause)
    else $error("remainder changed with no step or load");

  property p_rdata_idle;
    @(posedge clk_i) disable iff (rst_i)
      !re_i |=> (rdata_o == crc16_pkg::RDATA_RST);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not cleared outside the read window");

  property p_unmapped_read;
    @(posedge clk_i) disable iff (rst_i)
      (re_i && !sel_res && !sel_byte) |=> (rdata_o == crc16_pkg::UNMAPPED_RD);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read returned data");

  property p_rev_read_ends;
    @(posedge clk_i) disable iff (rst_i)
      rd_res |=> (rdata_o[15] == $past(rem_q[0]) && rdata_o[0] == $past(rem_q[15]));
  endproperty
  a_rev_read_ends: assert property (p_rev_read_ends)
    else $error("result read end bits not swapped");

endmodule : crc16_ccitt_byte_engine

// [hw/crc16_pkg.sv]
// package for the 16-bit ccitt byte crc engine: offsets, constants, types, functions
// assumes a single clock domain and a plain strobe register port
package crc16_pkg;

  // register port geometry
  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 16;
  localparam int          CRC_W       = 16;
  localparam int          BYTE_W      = 8;

  // register byte addresses
  localparam logic [ADDR_W-1:0] RESULT_OFF  = 4'h0;
  localparam logic [ADDR_W-1:0] BYTE_IN_OFF = 4'h4;

  // generator x^16 + x^12 + x^5 + 1, leading term implied
  localparam logic [CRC_W-1:0]  CCITT_POLY  = 16'h1021;

  // reset values
  localparam logic [CRC_W-1:0]  RESULT_RST  = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_RST    = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RST   = 16'h0000;
  localparam logic [DATA_W-1:0] UNMAPPED_RD = 16'h0000;

  // pending byte carried from the write cycle to the update cycle
  typedef struct packed {
    logic              pend;
    logic [BYTE_W-1:0] data;
  } byte_stage_t;

  localparam byte_stage_t STAGE_RST = '{pend: 1'b0, data: BYTE_RST};

  function automatic logic [BYTE_W-1:0] rev8(input logic [BYTE_W-1:0] v);
    logic [BYTE_W-1:0] r;
    r = '0;
    for (int i = 0; i < BYTE_W; i++) begin
      r[i] = v[BYTE_W-1-i];
    end
    return r;
  endfunction : rev8

  function automatic logic [CRC_W-1:0] rev16(input logic [CRC_W-1:0] v);
    logic [CRC_W-1:0] r;
    r = '0;
    for (int i = 0; i < CRC_W; i++) begin
      r[i] = v[CRC_W-1-i];
    end
    return r;
  endfunction : rev16

  // modulo-2 division of (byte * x^16) added to the running remainder, msb first
  function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0]  rem,
                                                input logic [BYTE_W-1:0] dvd);
    logic [CRC_W-1:0] r;
    logic             fb;
    r  = rem;
    fb = 1'b0;
    for (int i = BYTE_W - 1; i >= 0; i--) begin
      fb = r[CRC_W-1] ^ dvd[i];
      r  = {r[CRC_W-2:0], 1'b0};
      if (fb) begin
        r = r ^ CCITT_POLY;
      end
    end
    return r;
  endfunction : crc_step

endpackage : crc16_pkg

// [verif/tb_crc16_ccitt_byte_engine.sv]
// self-checking bench for the byte-fed 16-bit ccitt crc engine
// assumes the strobe register port of the package and a single 125 MHz clock
`timescale 1ns/1ps
module tb_crc16_ccitt_byte_engine;
  logic        clk_i;
  logic        rst_i;
  logic [3:0]  addr_i;
  logic [15:0] wdata_i;
  logic        we_i;
  logic        re_i;
  logic [15:0] rdata_o;
  logic [15:0] rem;
  logic [15:0] old;
  logic [31:0] seed;
  logic [7:0]  last_b;
  int          err_count;
  int          comparisons;
  int          n;

  crc16_ccitt_byte_engine dut (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .addr_i  (addr_i),
    .wdata_i (wdata_i),
    .we_i    (we_i),
    .re_i    (re_i),
    .rdata_o (rdata_o)
  );

  always #4 clk_i = ~clk_i;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // reference step: byte bit 0 enters first, as the msb of the dividend
  function automatic logic [15:0] step(logic [15:0] r, logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      r = (r[15] ^ b[i]) ? ({r[14:0], 1'b0} ^ 16'h1021) : {r[14:0], 1'b0};
    end
    return r;
  endfunction : step

  function automatic logic [15:0] flip(logic [15:0] v);
    logic [15:0] f;
    for (int i = 0; i < 16; i++) f[i] = v[15-i];
    return f;
  endfunction : flip

  task automatic final_report();
    if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one bus cycle, launched right after a rising edge
  task automatic op(logic w, logic r, logic [3:0] a, logic [15:0] d);
    @(posedge clk_i);
    we_i    <= w;
    re_i    <= r;
    addr_i  <= a;
    wdata_i <= d;
  endtask : op

  task automatic rd(string what, logic [3:0] a, logic [15:0] exp);
    op(1'b0, 1'b1, a, 16'h0000);
    op(1'b0, 1'b0, 4'h0, 16'h0000);
    #1 chk(what, exp, rdata_o);
    @(posedge clk_i);
    #1 chk("rdata_idle", 16'h0000, rdata_o);
  endtask : rd

  // byte write plus model update; upper data bits are random noise
  task automatic wb(logic [7:0] b);
    op(1'b1, 1'b0, 4'h4, {8'(rnd()), b});
    rem    = step(rem, b);
    last_b = b;
  endtask : wb

  initial begin
    clk_i = 1'b0; rst_i = 1'b1; addr_i = 4'h0; wdata_i = 16'h0000;
    we_i = 1'b0; re_i = 1'b0; seed = 32'd90866; err_count = 0; comparisons = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("result_rst", 4'h0, 16'h0000);
    rd("byte_rst", 4'h4, 16'h0000);
    op(1'b1, 1'b0, 4'h0, 16'h0000); rem = 16'h0000;
    wb(8'h00); wb(8'h80); op(1'b0, 1'b0, 4'h0, 16'h0000);
    rd("one_bit", 4'h0, flip(rem));
    wb(8'h5A); op(1'b1, 1'b0, 4'h0, 16'h0000); rem = 16'h0000;
    wb(8'h01); op(1'b0, 1'b0, 4'h0, 16'h0000);
    rd("example1", 4'h0, 16'h1189);
    wb(8'h23); op(1'b0, 1'b0, 4'h0, 16'h0000);
    rd("example2", 4'h0, 16'h0A41);
    old = flip(rem);
    wb(8'hA5);
    rd("early_read", 4'h0, old);
    rd("late_read", 4'h0, flip(rem));
    rd("unmapped_rd", 4'h8, 16'h0000);
    op(1'b1, 1'b0, 4'hC, 16'hFFFF);
    rd("unmapped_wr", 4'h0, flip(rem));
    for (int k = 0; k < 40; k++) begin
      rem = 16'(rnd());
      op(1'b1, 1'b0, 4'h0, rem);
      rd("load_back", 4'h0, flip(rem));
      n = 1 + (rnd() % 5);
      for (int j = 0; j < n; j++) wb(8'(rnd()));
      if (k == 0) begin
        for (int v = 0; v < 256; v++) wb(8'(v));
      end
      op(1'b0, 1'b0, 4'h0, 16'h0000);
      rd("rand_result", 4'h0, flip(rem));
      rd("byte_reg", 4'h4, {8'h00, last_b});
    end
    final_report();
  end

  // run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    final_report();
  end
endmodule : tb_crc16_ccitt_byte_engine
